/* File: core/memory_move_and_ram_config.sv */
// File: repeated word mover and on-chip RAM map control
`timescale 1ns/1ps
module memory_move_and_ram_config (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmdValid,
  input wire mem_move_pkg::move_cmd_type cmd,
  input wire logic mapBlockAsData,
  input wire logic mapBlockAsProgram,
  input wire logic fetchReq,
  input wire logic [mem_move_pkg::ADDR_W-1:0] fetchAddr,
  input wire logic extAck,
  input wire logic [mem_move_pkg::WORD_W-1:0] extRdata,
  output mem_move_pkg::ext_req_type extReq,
  output mem_move_pkg::space_type extSpace,
  output logic cmdBusy,
  output logic cmdDone,
  output logic [mem_move_pkg::ADDR_W-1:0] auxPointerOut,
  output logic blockIsProgram,
  output logic fetchValid,
  output logic [mem_move_pkg::WORD_W-1:0] fetchData
);
  import mem_move_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_READ_WAIT = 3'b010,
    ST_WRITE = 3'b011,
    ST_WRITE_WAIT = 3'b100,
    ST_FETCH = 3'b101
  } state_type;

  state_type state;
  move_op_type op;
  logic [ADDR_W-1:0] srcAddr;
  logic [ADDR_W-1:0] dstAddr;
  logic [7:0] remaining;
  logic [WORD_W-1:0] word;
  logic srcIsData;
  logic dstIsData;
  logic srcPointerMoves;
  logic rdInternal;
  logic ramSel;

  // Map of a data address onto the two on-chip blocks
  function automatic logic [1:0] data_block_hit(input logic [ADDR_W-1:0] a, input logic isProg);
    logic [1:0] hit;
    hit = 2'b00;
    if (!isProg && a >= RECONF_DATA_BASE && a < RECONF_DATA_BASE + BLOCK_SIZE) begin
      hit = 2'b01;
    end
    if (a >= SECOND_DATA_BASE && a < SECOND_DATA_BASE + BLOCK_SIZE) begin
      hit = 2'b10;
    end
    return hit;
  endfunction

  // Program fetch hit on the reconfigurable block
  function automatic logic prog_block_hit(input logic [ADDR_W-1:0] a, input logic isProg);
    return isProg && a >= RECONF_PROG_BASE;
  endfunction

  // Which side of each operation is in data space
  always_comb begin
    srcIsData = (op == OP_DATA_BLOCK_MOVE) || (op == OP_TABLE_WRITE) || (op == OP_PORT_OUT);
    dstIsData = !((op == OP_TABLE_WRITE) || (op == OP_PORT_OUT));
    srcPointerMoves = (op == OP_TABLE_WRITE) || (op == OP_PORT_OUT);
  end

  // RAM port signals
  logic reconfWe;
  logic secondWe;
  logic [BLOCK_W-1:0] reconfAddr;
  logic [BLOCK_W-1:0] secondAddr;
  logic [WORD_W-1:0] reconfRdata;
  logic [WORD_W-1:0] secondRdata;
  logic [1:0] srcHit;
  logic [1:0] dstHit;

  always_comb begin
    srcHit = srcIsData ? data_block_hit(srcAddr, blockIsProgram) : 2'b00;
    dstHit = dstIsData ? data_block_hit(dstAddr, blockIsProgram) : 2'b00;
    reconfWe = (state == ST_WRITE) && (dstHit == 2'b01);
    secondWe = (state == ST_WRITE) && (dstHit == 2'b10);
    reconfAddr = srcAddr[BLOCK_W-1:0];
    secondAddr = srcAddr[BLOCK_W-1:0];
    if (state == ST_WRITE) begin
      reconfAddr = dstAddr[BLOCK_W-1:0];
      secondAddr = dstAddr[BLOCK_W-1:0];
    end else if (state == ST_IDLE || state == ST_FETCH) begin
      reconfAddr = fetchAddr[BLOCK_W-1:0];
    end
  end

  onchip_ram #(.DEPTH_W(BLOCK_W), .WIDTH(WORD_W)) reconfigurableRamBlock (
    .sys_clk(sys_clk),
    .writeEn(reconfWe),
    .addr(reconfAddr),
    .wdata(word),
    .rdata(reconfRdata)
  );

  onchip_ram #(.DEPTH_W(BLOCK_W), .WIDTH(WORD_W)) secondDataRamBlock (
    .sys_clk(sys_clk),
    .writeEn(secondWe),
    .addr(secondAddr),
    .wdata(word),
    .rdata(secondRdata)
  );

  // Map of the reconfigurable block; RAM itself is never touched here
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      blockIsProgram <= 1'b0;
    end else if (mapBlockAsData) begin
      blockIsProgram <= 1'b0;
    end else if (mapBlockAsProgram) begin
      blockIsProgram <= 1'b1;
    end
  end

  // Move sequencer: read one word, write it, repeat
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      op <= OP_DATA_BLOCK_MOVE;
      srcAddr <= '0;
      dstAddr <= '0;
      remaining <= COUNT_ZERO;
      word <= '0;
      ramSel <= 1'b0;
      rdInternal <= 1'b0;
      extReq <= '0;
      extSpace <= SPACE_DATA;
      cmdBusy <= 1'b0;
      cmdDone <= 1'b0;
      fetchValid <= 1'b0;
      fetchData <= '0;
    end else begin
      cmdDone <= 1'b0;
      fetchValid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cmdValid) begin
            op <= cmd.op;
            remaining <= cmd.repeatCount;
            cmdBusy <= 1'b1;
            state <= ST_READ;
            case (cmd.op)
              OP_DATA_BLOCK_MOVE, OP_PROGRAM_TO_DATA_BLOCK_MOVE: begin
                srcAddr <= cmd.immAddr;
                dstAddr <= cmd.auxPointerTwo;
              end
              OP_TABLE_READ: begin
                srcAddr <= cmd.accAddr;
                dstAddr <= cmd.auxPointerTwo;
              end
              OP_TABLE_WRITE: begin
                srcAddr <= cmd.auxPointerTwo;
                dstAddr <= cmd.accAddr;
              end
              OP_PORT_IN: begin
                srcAddr <= {{(ADDR_W-PORT_W){1'b0}}, cmd.port};
                dstAddr <= cmd.auxPointerTwo;
              end
              default: begin
                srcAddr <= cmd.auxPointerTwo;
                dstAddr <= {{(ADDR_W-PORT_W){1'b0}}, cmd.port};
              end
            endcase
          end else if (fetchReq && prog_block_hit(fetchAddr, blockIsProgram)) begin
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          fetchData <= reconfRdata;
          fetchValid <= 1'b1;
          state <= ST_IDLE;
        end
        ST_READ: begin
          if (srcHit != 2'b00) begin
            rdInternal <= 1'b1;
            ramSel <= srcHit[1];
            state <= ST_READ_WAIT;
          end else begin
            rdInternal <= 1'b0;
            extReq.req <= 1'b1;
            extReq.write <= 1'b0;
            extReq.addr <= srcAddr;
            extSpace <= srcIsData ? SPACE_DATA : (op == OP_PORT_IN ? SPACE_IO : SPACE_PROG);
            state <= ST_READ_WAIT;
          end
        end
        ST_READ_WAIT: begin
          if (rdInternal) begin
            word <= ramSel ? secondRdata : reconfRdata;
            state <= ST_WRITE;
          end else if (extAck) begin
            word <= extRdata;
            extReq.req <= 1'b0;
            state <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (dstHit != 2'b00) begin
            state <= ST_WRITE_WAIT;
          end else begin
            extReq.req <= 1'b1;
            extReq.write <= 1'b1;
            extReq.addr <= dstAddr;
            extReq.wdata <= word;
            extSpace <= dstIsData ? SPACE_DATA : (op == OP_PORT_OUT ? SPACE_IO : SPACE_PROG);
            rdInternal <= 1'b0;
            state <= ST_WRITE_WAIT;
          end
          rdInternal <= (dstHit != 2'b00);
        end
        ST_WRITE_WAIT: begin
          if (rdInternal || extAck) begin
            extReq.req <= 1'b0;
            if (srcPointerMoves) begin
              srcAddr <= srcAddr + ADDR_ONE;
            end else begin
              dstAddr <= dstAddr + ADDR_ONE;
            end
            if (op == OP_DATA_BLOCK_MOVE || op == OP_PROGRAM_TO_DATA_BLOCK_MOVE) begin
              srcAddr <= srcAddr + ADDR_ONE;
            end
            if (op == OP_TABLE_READ) begin
              srcAddr <= srcAddr + ADDR_ONE;
            end
            if (op == OP_TABLE_WRITE) begin
              dstAddr <= dstAddr + ADDR_ONE;
            end
            if (remaining == COUNT_ZERO) begin
              cmdBusy <= 1'b0;
              cmdDone <= 1'b1;
              state <= ST_IDLE;
            end else begin
              remaining <= remaining - 8'h01;
              state <= ST_READ;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Current pointer value shown to the register file
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      auxPointerOut <= '0;
    end else begin
      auxPointerOut <= srcPointerMoves ? srcAddr : dstAddr;
    end
  end
endmodule

/* File: pkg/mem_move_pkg.sv */
// Package: constants and carrier types for the memory move and RAM map block
package mem_move_pkg;

  localparam int WORD_W = 16;
  localparam int ADDR_W = 16;
  localparam int PORT_W = 4;
  localparam int BLOCK_W = 8;

  // Reconfigurable block base in the data map (decimal 512) and in the program map
  localparam logic [ADDR_W-1:0] RECONF_DATA_BASE = 16'h0200;
  localparam logic [ADDR_W-1:0] RECONF_PROG_BASE = 16'hFF00;
  // Second data block: pages 6 and 7
  localparam logic [ADDR_W-1:0] SECOND_DATA_BASE = 16'h0300;
  localparam logic [ADDR_W-1:0] BLOCK_SIZE = 16'h0100;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
  localparam logic [7:0] COUNT_ZERO = 8'h00;

  // Move operations
  typedef enum logic [2:0] {
    OP_DATA_BLOCK_MOVE = 3'b000,
    OP_PROGRAM_TO_DATA_BLOCK_MOVE = 3'b001,
    OP_TABLE_READ = 3'b010,
    OP_TABLE_WRITE = 3'b011,
    OP_PORT_IN = 3'b100,
    OP_PORT_OUT = 3'b101
  } move_op_type;

  // One move command from the instruction sequencer
  typedef struct packed {
    move_op_type op;
    logic [ADDR_W-1:0] immAddr;
    logic [ADDR_W-1:0] accAddr;
    logic [ADDR_W-1:0] auxPointerTwo;
    logic [PORT_W-1:0] port;
    logic [7:0] repeatCount;
  } move_cmd_type;

  // External bus request
  typedef struct packed {
    logic req;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } ext_req_type;

  typedef enum logic [1:0] {
    SPACE_DATA = 2'b00,
    SPACE_PROG = 2'b01,
    SPACE_IO = 2'b10
  } space_type;

endpackage

/* File: core/onchip_ram.sv */
// File: single-port on-chip RAM block used for both data blocks
`timescale 1ns/1ps
module onchip_ram #(
  parameter int DEPTH_W = mem_move_pkg::BLOCK_W,
  parameter int WIDTH = mem_move_pkg::WORD_W
) (
  input wire logic sys_clk,
  input wire logic writeEn,
  input wire logic [DEPTH_W-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
  import mem_move_pkg::*;

  logic [WIDTH-1:0] mem [0:(1<<DEPTH_W)-1];

  // Contents are never cleared, so remapping keeps them
  always_ff @(posedge sys_clk) begin
    if (writeEn) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

/* File: sim/move_checker_properties.sv */
// Checker: port properties of the move and RAM map block
`timescale 1ns/1ps
module move_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmdValid,
  input wire logic mapBlockAsData,
  input wire logic mapBlockAsProgram,
  input wire logic fetchReq,
  input wire logic [mem_move_pkg::ADDR_W-1:0] fetchAddr,
  input wire logic extAck,
  input wire mem_move_pkg::ext_req_type extReq,
  input wire logic cmdBusy,
  input wire logic cmdDone,
  input wire logic [mem_move_pkg::ADDR_W-1:0] auxPointerOut,
  input wire logic blockIsProgram,
  input wire logic fetchValid
);
  import mem_move_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Fetch taken from the program-mapped block, then a one-cycle answer
  sequence fetchTaken;
    fetchReq && blockIsProgram && fetchAddr >= RECONF_PROG_BASE && !cmdBusy && !cmdValid && !$past(fetchReq);
  endsequence
  sequence fetchAnswer;
    ##2 fetchValid ##1 !fetchValid;
  endsequence
  chk_fetch_answer: assert property (fetchTaken |-> fetchAnswer) else $error("fetch unanswered");
  chk_fetch_refused: assert property (fetchReq && !blockIsProgram |-> ##2 !fetchValid) else $error("bad fetch");
  chk_map_program: assert property (mapBlockAsProgram && !mapBlockAsData |=> blockIsProgram) else $error("map");
  chk_map_data: assert property (mapBlockAsData |=> !blockIsProgram) else $error("map data");
  chk_reset_map: assert property (disable iff (1'b0) sys_rst |=> !blockIsProgram && !extReq.req)
    else $error("reset map");
  chk_cmd_taken: assert property (cmdValid && !cmdBusy && !fetchReq && !fetchValid && !$past(fetchReq)
    |=> cmdBusy) else $error("cmd lost");
  chk_req_holds: assert property (extReq.req && !extAck |=> extReq.req && $stable(extReq)) else $error("req");
  chk_idle_quiet: assert property (!cmdBusy |-> !extReq.req) else $error("idle req");
  chk_done_pulse: assert property (cmdDone |-> !cmdBusy ##1 !cmdDone) else $error("done");
  chk_ptr_step: assert property ($changed(auxPointerOut) && cmdBusy && $past(cmdBusy, 2)
    |-> auxPointerOut == $past(auxPointerOut) + ADDR_ONE) else $error("pointer step");
endmodule
bind memory_move_and_ram_config move_checker u_chk (.sys_clk, .sys_rst, .cmdValid, .mapBlockAsData,
  .mapBlockAsProgram, .fetchReq, .fetchAddr, .extAck, .extReq, .cmdBusy, .cmdDone, .auxPointerOut,
  .blockIsProgram, .fetchValid);

/* File: sim/ext_mem_model.sv */
// Partner: external memories and ports with adjustable wait states
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire mem_move_pkg::ext_req_type extReq,
  input wire logic [1:0] waitStates,
  output logic extAck,
  output logic [mem_move_pkg::WORD_W-1:0] extRdata
);
  import mem_move_pkg::*;
  logic [1:0] waitCnt;
  logic go;
  assign go = extReq.req && !extAck && waitCnt == waitStates;
  // Acknowledge once the wait states have passed
  always_ff @(posedge sys_clk) begin
    extAck <= !sys_rst && go;
    waitCnt <= (!sys_rst && extReq.req && !extAck && !go) ? waitCnt + 2'h1 : 2'h0;
  end
  // Read data valid only with the acknowledge; otherwise it keeps changing
  always_ff @(posedge sys_clk) begin
    extRdata <= sys_rst ? 16'h0000 : (go ? extReq.addr ^ 16'h5A5A : ~extRdata);
  end
endmodule

/* File: sim/memory_move_and_ram_config_tb.sv */
// Testbench: block, table and port moves and RAM remapping
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t got %h", $time, g); end end
module memory_move_and_ram_config_tb;
  import mem_move_pkg::*;
  logic sys_clk, sys_rst, cmdValid, mapBlockAsData, mapBlockAsProgram, fetchReq, extAck, cmdBusy, cmdDone;
  logic blockIsProgram, fetchValid;
  logic [15:0] fetchAddr, extRdata, auxPointerOut, fetchData, ex[4];
  logic [1:0] waitStates;
  move_cmd_type cmd;
  ext_req_type extReq;
  space_type extSpace;
  logic [34:0] log[$];
  int mismatches = 0;
  int cmp_count = 0;
  memory_move_and_ram_config dut (.sys_clk, .sys_rst, .cmdValid, .cmd, .mapBlockAsData, .mapBlockAsProgram,
    .fetchReq, .fetchAddr, .extAck, .extRdata, .extReq, .extSpace, .cmdBusy, .cmdDone, .auxPointerOut,
    .blockIsProgram, .fetchValid, .fetchData);
  ext_mem_model mem (.sys_clk, .sys_rst, .extReq, .waitStates, .extAck, .extRdata);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Log each completed external access
  always @(posedge sys_clk) begin
    if (extReq.req && extAck) begin
      log.push_back({extReq.write, extSpace, extReq.addr,
        extReq.write ? extReq.wdata : 16'h0000});
    end
  end
  function automatic logic [34:0] ent(logic w, space_type s, logic [15:0] a, logic [15:0] d);
    return {w, s, a, d};
  endfunction
  task automatic send(move_op_type op, logic [15:0] imm, logic [15:0] acc, logic [15:0] ptr, logic [3:0] pt,
    logic [7:0] n);
    int i;
    repeat (2) @(negedge sys_clk);
    log.delete();
    cmd = '{op, imm, acc, ptr, pt, n};
    cmdValid = 1'b1;
    @(negedge sys_clk);
    cmdValid = 1'b0;
    for (i = 0; i < 3000 && cmdDone !== 1'b1; i++) @(negedge sys_clk);
    `CHK(cmdDone, 1'b1)
  endtask
  task automatic pulse(input logic forProgram);
    mapBlockAsProgram = forProgram;
    mapBlockAsData = !forProgram;
    @(negedge sys_clk);
    mapBlockAsProgram = 1'b0;
    mapBlockAsData = 1'b0;
    `CHK(blockIsProgram, forProgram)
  endtask
  task automatic fetch(input logic [15:0] a, input logic expValid);
    fetchAddr = a;
    fetchReq = 1'b1;
    @(negedge sys_clk);
    fetchReq = 1'b0;
    @(negedge sys_clk);
    `CHK(fetchValid, expValid)
  endtask
  task automatic t_moves;
    `CHK(blockIsProgram, 1'b0)
    waitStates = 2'h3;
    send(OP_PROGRAM_TO_DATA_BLOCK_MOVE, 16'h0002, 16'h0000, RECONF_DATA_BASE, 4'h0, 8'h03);
    `CHK(log.size(), 4)
    for (int i = 0; i < 4; i++) `CHK(log[i], ent(0, SPACE_PROG, 16'h0002 + 16'(i), 16'h0000))
    waitStates = 2'h0;
    send(OP_TABLE_WRITE, 16'h0000, 16'h0040, RECONF_DATA_BASE, 4'h0, 8'h03);
    `CHK(log.size(), 4)
    for (int i = 0; i < 4; i++) `CHK(log[i], ent(1, SPACE_PROG, 16'h0040 + 16'(i), 16'(i + 2) ^ 16'h5A5A))
    $display("move test done");
  endtask
  task automatic t_remap;
    pulse(1'b1);
    fetch(16'hFF01, 1'b1);
    `CHK(fetchData, 16'h0003 ^ 16'h5A5A)
    fetch(16'h0001, 1'b0);
    send(OP_PORT_OUT, 16'h0000, 16'h0000, RECONF_DATA_BASE, 4'h8, 8'h00);
    `CHK(log[0], ent(0, SPACE_DATA, RECONF_DATA_BASE, 16'h0000))
    `CHK(log[1], ent(1, SPACE_IO, 16'h0008, RECONF_DATA_BASE ^ 16'h5A5A))
    pulse(1'b0);
    fetch(16'hFF01, 1'b0);
    send(OP_PORT_OUT, 16'h0000, 16'h0000, 16'h0201, 4'hF, 8'h00);
    `CHK(log.size(), 1)
    `CHK(log[0], ent(1, SPACE_IO, 16'h000F, 16'h0003 ^ 16'h5A5A))
    $display("remap test done");
  endtask
  task automatic t_second;
    send(OP_TABLE_READ, 16'h0000, 16'h0010, SECOND_DATA_BASE, 4'h0, 8'h00);
    `CHK(log[0], ent(0, SPACE_PROG, 16'h0010, 16'h0000))
    send(OP_PORT_IN, 16'h0000, 16'h0000, 16'h0301, 4'hF, 8'h00);
    `CHK(log[0], ent(0, SPACE_IO, 16'h000F, 16'h0000))
    send(OP_DATA_BLOCK_MOVE, 16'h0400, 16'h0000, 16'h0302, 4'h0, 8'h01);
    `CHK(log.size(), 2)
    ex = '{16'h0010, 16'h000F, 16'h0400, 16'h0401};
    send(OP_PORT_OUT, 16'h0000, 16'h0000, SECOND_DATA_BASE, 4'h3, 8'h03);
    for (int i = 0; i < 4; i++) `CHK(log[i], ent(1, SPACE_IO, 16'h0003, ex[i] ^ 16'h5A5A))
    send(OP_DATA_BLOCK_MOVE, 16'h0500, 16'h0000, SECOND_DATA_BASE, 4'h0, 8'hFF);
    `CHK(log.size(), 256)
    `CHK(log[255], ent(0, SPACE_DATA, 16'h05FF, 16'h0000))
    @(negedge sys_clk);
    `CHK(auxPointerOut, SECOND_DATA_BASE + BLOCK_SIZE)
    $display("second block test done");
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial begin
    {sys_rst, cmdValid, mapBlockAsData, mapBlockAsProgram, fetchReq} = 5'b10000;
    {fetchAddr, waitStates, cmd} = '0;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    t_moves();
    t_remap();
    t_second();
    final_report();
  end
  // Watchdog
  initial begin
    #2000000;
    mismatches++;
    final_report();
  end
endmodule
